// ---- icp_pkg.sv ----
package icp_pkg;
    localparam int NUM_SRC  = 14;
    localparam int IDX_W    = 4;
    localparam int DATA_W   = 32;
    localparam int OFF_W    = 8;
    localparam int EN_W     = 8;
    localparam int EN_LOW_W = 7;
    localparam int VEC_W    = 16;
    localparam int EVT_W    = 2;
    localparam int LVL_W    = 2;
    localparam int PIN_NUM  = 2;

    // Register byte offsets on the AHB-Lite bus.
    localparam logic [OFF_W-1:0] OFF_EN_MAIN = 8'h00;
    localparam logic [OFF_W-1:0] OFF_EN_EXT1 = 8'h04;
    localparam logic [OFF_W-1:0] OFF_PRIO    = 8'h08;
    localparam logic [OFF_W-1:0] OFF_PEND    = 8'h0C;
    localparam logic [OFF_W-1:0] OFF_AUTOCLR = 8'h10;
    localparam logic [OFF_W-1:0] OFF_SVC     = 8'h14;
    localparam logic [OFF_W-1:0] OFF_EVT     = 8'h18;
    localparam logic [OFF_W-1:0] OFF_EVT_MSK = 8'h1C;

    localparam int GLOBAL_BIT = 7;
    localparam int EVT_VEC    = 0;
    localparam int EVT_REENT  = 1;
    localparam int LVL_LO     = 0;
    localparam int LVL_HI     = 1;
    localparam int HTRANS_BIT = 1;

    // External pins feed these source positions on a falling edge.
    localparam int PIN_SRC0 = 0;
    localparam int PIN_SRC1 = 2;

    localparam logic [EN_W-1:0]    EN_RST   = 8'h00;
    localparam logic [NUM_SRC-1:0] SRC_ZERO = 14'h0000;
    localparam logic [EVT_W-1:0]   EVT_ZERO = 2'h0;
    localparam logic [LVL_W-1:0]   LVL_ZERO = 2'h0;

    localparam logic [VEC_W-1:0] VEC_BASE  = 16'h0003;
    localparam int               VEC_SHIFT = 3;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_OFFER = 2'b01
    } icp_state_type;
endpackage : icp_pkg

// ---- icp_pin_sync.sv ----
module icp_pin_sync
    import icp_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic resetn_in,
    input  wire logic pin_in,
    output logic      fall_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic lvl_d;

    // A change counts only once the second and third stages agree.
    assign lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            s1_q     <= 1'b1;
            s2_q     <= 1'b1;
            s3_q     <= 1'b1;
            lvl_q    <= 1'b1;
            fall_out <= 1'b0;
        end else begin
            s1_q     <= pin_in;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            lvl_q    <= lvl_d;
            fall_out <= lvl_q & ~lvl_d;
        end
    end
endmodule : icp_pin_sync

// ---- icp_pick.sv ----
module icp_pick
    import icp_pkg::*;
(
    input  wire logic [NUM_SRC-1:0] req_in,
    output logic                    found_out,
    output logic [IDX_W-1:0]        idx_out
);
    // Lowest index wins among simultaneous requests.
    function automatic logic [IDX_W-1:0] first_set(
        input logic [NUM_SRC-1:0] v
    );
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IDX_W'(i);
            end
        end
        return r;
    endfunction : first_set

    assign found_out = |req_in;
    assign idx_out   = first_set(req_in);
endmodule : icp_pick

// ---- icp_ctrl.sv ----
// Overview of operation
// - Fourteen sources, each high or low level.
// - Source condition sets its pending flag.
// - Flags set even when disabled; then ignored.
// - Enabled set flag raises request to CPU.
// - Vector call after current instruction completes.
// - Return resumes the interrupted instruction stream.
// - Each source has its own enable bit.
// - Enables count only while global bit set.
// - Global bit clear blocks every source but a late request.
// - Late request kept if single-cycle follows.
// - Multi-cycle follower drops late request.
// - Some flags hardware-cleared on vector call.
// - Flag left set: re-enter after one instruction.
module icp_ctrl
    import icp_pkg::*;
(
    input  wire logic               ref_clk_in,
    input  wire logic               resetn_in,
    input  wire logic               hsel_in,
    input  wire logic [DATA_W-1:0]  haddr_in,
    input  wire logic [1:0]         htrans_in,
    input  wire logic               hwrite_in,
    input  wire logic [2:0]         hsize_in,
    input  wire logic [DATA_W-1:0]  hwdata_in,
    input  wire logic               hready_in,
    output logic                    hreadyout_out,
    output logic                    hresp_out,
    output logic [DATA_W-1:0]       hrdata_out,
    input  wire logic [NUM_SRC-1:0] src_event_in,
    input  wire logic [PIN_NUM-1:0] ext_pin_in,
    input  wire logic               instr_done_in,
    input  wire logic               instr_multi_in,
    input  wire logic               ret_done_in,
    input  wire logic               vec_ack_in,
    output logic                    irq_req_out,
    output logic                    vec_valid_out,
    output logic [VEC_W-1:0]        vec_addr_out,
    output logic [IDX_W-1:0]        vec_src_out,
    output logic                    irq_out
);
    function automatic logic hit(
        input logic [OFF_W-1:0] a,
        input logic [OFF_W-1:0] off
    );
        return a == off;
    endfunction : hit

    logic [EN_W-1:0]     en_main_q;
    logic [EN_LOW_W-1:0] en_ext1_q;
    logic [NUM_SRC-1:0]  prio_q;
    logic [NUM_SRC-1:0]  autoclr_q;
    logic [NUM_SRC-1:0]  pend_q;
    logic [NUM_SRC-1:0]  pend_d;
    logic [NUM_SRC-1:0]  late_q;
    logic [EVT_W-1:0]    evt_q;
    logic [EVT_W-1:0]    evt_mask_q;
    logic [LVL_W-1:0]    in_svc_q;
    logic                ret_hold_q;
    logic                vec_lvl_q;
    icp_state_type       st_q;
    logic                wr_q;
    logic [OFF_W-1:0]    waddr_q;
    logic [DATA_W-1:0]   hrdata_q;
    logic [VEC_W-1:0]    vec_addr_q;
    logic [IDX_W-1:0]    vec_src_q;

    logic [NUM_SRC-1:0] en_eff;
    logic [NUM_SRC-1:0] live;
    logic [NUM_SRC-1:0] cand;
    logic [NUM_SRC-1:0] src_set;
    logic [NUM_SRC-1:0] sw_clr;
    logic [NUM_SRC-1:0] hw_clr;
    logic [PIN_NUM-1:0] pin_fall;
    logic [OFF_W-1:0]   raddr;
    logic [OFF_W-1:0]   aoff;
    logic               addr_ok;
    logic               rd_take;
    logic               wr_take;
    logic               hi_found;
    logic               lo_found;
    logic [IDX_W-1:0]   hi_idx;
    logic [IDX_W-1:0]   lo_idx;
    logic               boundary;
    logic               take_hi;
    logic               take_lo;
    logic               ack_take;
    logic [EVT_W-1:0]   evt_set;
    logic [EVT_W-1:0]   evt_clr;

    // Bus slave: zero wait states, always OKAY.
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = hrdata_q;
    assign aoff    = haddr_in[OFF_W-1:0];
    assign raddr   = aoff;
    assign addr_ok = hsel_in & hready_in & htrans_in[HTRANS_BIT];
    assign rd_take = addr_ok & ~hwrite_in;
    assign wr_take = addr_ok & hwrite_in;

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            wr_q    <= 1'b0;
            waddr_q <= '0;
        end else begin
            wr_q    <= wr_take;
            waddr_q <= aoff;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            hrdata_q <= '0;
        end else if (rd_take) begin
            case (1'b1)
                hit(raddr, OFF_EN_MAIN): hrdata_q <= DATA_W'(en_main_q);
                hit(raddr, OFF_EN_EXT1): hrdata_q <= DATA_W'(en_ext1_q);
                hit(raddr, OFF_PRIO):    hrdata_q <= DATA_W'(prio_q);
                hit(raddr, OFF_PEND):    hrdata_q <= DATA_W'(pend_q);
                hit(raddr, OFF_AUTOCLR): hrdata_q <= DATA_W'(autoclr_q);
                hit(raddr, OFF_SVC): begin
                    hrdata_q <= DATA_W'({st_q, vec_src_q, in_svc_q});
                end
                hit(raddr, OFF_EVT):     hrdata_q <= DATA_W'(evt_q);
                hit(raddr, OFF_EVT_MSK): hrdata_q <= DATA_W'(evt_mask_q);
                default:                 hrdata_q <= '0;
            endcase
        end
    end

    // Control registers written in the data phase.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            en_main_q  <= EN_RST;
            en_ext1_q  <= EN_RST[EN_LOW_W-1:0];
            prio_q     <= SRC_ZERO;
            autoclr_q  <= SRC_ZERO;
            evt_mask_q <= EVT_ZERO;
        end else if (wr_q) begin
            if (hit(waddr_q, OFF_EN_MAIN)) begin
                en_main_q <= hwdata_in[EN_W-1:0];
            end
            if (hit(waddr_q, OFF_EN_EXT1)) begin
                en_ext1_q <= hwdata_in[EN_LOW_W-1:0];
            end
            if (hit(waddr_q, OFF_PRIO)) begin
                prio_q <= hwdata_in[NUM_SRC-1:0];
            end
            if (hit(waddr_q, OFF_AUTOCLR)) begin
                autoclr_q <= hwdata_in[NUM_SRC-1:0];
            end
            if (hit(waddr_q, OFF_EVT_MSK)) begin
                evt_mask_q <= hwdata_in[EVT_W-1:0];
            end
        end
    end

    // Individual enables gated by the global bit.
    assign en_eff = en_main_q[GLOBAL_BIT] ?
                    {en_ext1_q, en_main_q[EN_LOW_W-1:0]} :
                    SRC_ZERO;
    assign live        = pend_q & en_eff;
    assign irq_req_out = |live;

    genvar gp;
    generate
        for (gp = 0; gp < PIN_NUM; gp++) begin : g_pin
            icp_pin_sync u_sync (
                .ref_clk_in (ref_clk_in),
                .resetn_in  (resetn_in),
                .pin_in     (ext_pin_in[gp]),
                .fall_out   (pin_fall[gp])
            );
        end
    endgenerate

    always_comb begin
        src_set = src_event_in;
        src_set[PIN_SRC0] = src_event_in[PIN_SRC0] | pin_fall[0];
        src_set[PIN_SRC1] = src_event_in[PIN_SRC1] | pin_fall[1];
    end

    assign sw_clr = (wr_q && hit(waddr_q, OFF_PEND)) ?
                    hwdata_in[NUM_SRC-1:0] : SRC_ZERO;
    assign ack_take = (st_q == ST_OFFER) & vec_ack_in;

    // A new event in the clearing cycle wins over both clears.
    genvar gs;
    generate
        for (gs = 0; gs < NUM_SRC; gs++) begin : g_src
            assign hw_clr[gs] = ack_take & autoclr_q[gs] &
                                (vec_src_q == IDX_W'(gs));
            assign pend_d[gs] = src_set[gs] |
                                (pend_q[gs] & ~sw_clr[gs] &
                                 ~hw_clr[gs]);
        end
    endgenerate

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            pend_q <= SRC_ZERO;
        end else begin
            pend_q <= pend_d;
        end
    end

    // Requests seen during the instruction in progress.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            late_q <= SRC_ZERO;
        end else if (instr_done_in) begin
            late_q <= SRC_ZERO;
        end else begin
            late_q <= late_q | live;
        end
    end

    // A late request survives only a single-cycle follower.
    assign cand = instr_multi_in ? live :
                  (live | (late_q & pend_q));

    icp_pick u_pick_hi (
        .req_in    (cand & prio_q),
        .found_out (hi_found),
        .idx_out   (hi_idx)
    );

    icp_pick u_pick_lo (
        .req_in    (cand & ~prio_q),
        .found_out (lo_found),
        .idx_out   (lo_idx)
    );

    // A return's own boundary never vectors; the next one may.
    assign boundary = instr_done_in & ~ret_done_in &
                      (st_q == ST_IDLE);
    assign take_hi  = boundary & hi_found & ~in_svc_q[LVL_HI];
    assign take_lo  = boundary & ~take_hi & lo_found &
                      (in_svc_q == LVL_ZERO);

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            ret_hold_q <= 1'b0;
        end else if (ret_done_in) begin
            ret_hold_q <= 1'b1;
        end else if (instr_done_in) begin
            ret_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            st_q       <= ST_IDLE;
            vec_src_q  <= '0;
            vec_addr_q <= '0;
            vec_lvl_q  <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (take_hi || take_lo) begin
                        st_q       <= ST_OFFER;
                        vec_src_q  <= take_hi ? hi_idx : lo_idx;
                        vec_lvl_q  <= take_hi;
                        vec_addr_q <= VEC_BASE + (VEC_W'(take_hi ?
                                      hi_idx : lo_idx) << VEC_SHIFT);
                    end
                end
                ST_OFFER: begin
                    if (vec_ack_in) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    assign vec_valid_out = (st_q == ST_OFFER);
    assign vec_addr_out  = vec_addr_q;
    assign vec_src_out   = vec_src_q;

    // Service nesting: the return pops the highest active level.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            in_svc_q <= LVL_ZERO;
        end else if (ack_take) begin
            in_svc_q[vec_lvl_q] <= 1'b1;
        end else if (ret_done_in) begin
            if (in_svc_q[LVL_HI]) begin
                in_svc_q[LVL_HI] <= 1'b0;
            end else begin
                in_svc_q[LVL_LO] <= 1'b0;
            end
        end
    end

    // Block events: vector taken, return with a flag still set.
    always_comb begin
        evt_set = EVT_ZERO;
        evt_set[EVT_VEC]   = ack_take;
        evt_set[EVT_REENT] = ret_done_in & (|live);
    end
    assign evt_clr = (wr_q && hit(waddr_q, OFF_EVT)) ?
                     hwdata_in[EVT_W-1:0] : EVT_ZERO;

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            evt_q <= EVT_ZERO;
        end else begin
            evt_q <= evt_set | (evt_q & ~evt_clr);
        end
    end

    assign irq_out = |(evt_q & evt_mask_q);

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_step_after_ret;
        instr_done_in && !ret_done_in && ret_hold_q;
    endsequence

    a_flag_set_hold: assert property (
        (src_set != SRC_ZERO) |=>
        ((pend_q & $past(src_set)) == $past(src_set)))
        else $error("pending flag not set by its event");

    a_global_block: assert property (
        !en_main_q[GLOBAL_BIT] |-> !irq_req_out)
        else $error("request raised with global enable clear");

    a_req_raise: assert property (
        ((pend_q & en_eff) != SRC_ZERO) |-> irq_req_out)
        else $error("enabled pending flag gave no request");

    a_vec_boundary: assert property (
        $rose(vec_valid_out) |-> $past(instr_done_in))
        else $error("vector offered off an instruction boundary");

    a_vec_addr: assert property (
        vec_valid_out |-> (vec_addr_out ==
        VEC_BASE + (VEC_W'(vec_src_out) << VEC_SHIFT)))
        else $error("vector address does not match source");

    a_ret_skip: assert property (
        (ret_done_in && st_q == ST_IDLE) |=> (st_q == ST_IDLE))
        else $error("vector taken at the return boundary");

    a_ret_reenter: assert property (
        s_step_after_ret ##0 (st_q == ST_IDLE &&
        in_svc_q == LVL_ZERO && live != SRC_ZERO) |=> vec_valid_out)
        else $error("no re-entry after one instruction");

    a_auto_clear: assert property (
        (ack_take && autoclr_q[vec_src_q] &&
         !src_set[vec_src_q]) |=> !pend_q[$past(vec_src_q)])
        else $error("auto-clear flag survived the vector call");

    a_multi_block: assert property (
        (instr_done_in && instr_multi_in && live == SRC_ZERO &&
         st_q == ST_IDLE) |=> (st_q == ST_IDLE))
        else $error("late request taken before multi-cycle step");

    a_prio_preempt: assert property (
        (in_svc_q[LVL_HI] && st_q == ST_IDLE && !ret_done_in)
        |=> (st_q == ST_IDLE))
        else $error("vector offered while high level in service");
endmodule : icp_ctrl

// ---- icp_cpu_model.sv ----
module icp_cpu_model
    import icp_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       resetn_in,
    input  wire logic       go_in,
    input  wire logic       multi_in,
    input  wire logic       ret_in,
    input  wire logic [1:0] ack_delay_in,
    input  wire logic       vec_valid_in,
    output logic            instr_done_out,
    output logic            instr_multi_out,
    output logic            ret_done_out,
    output logic            vec_ack_out
);
    logic [1:0] wait_q;

    // The kind flag only means something with an instruction end, so it
    // toggles between ends to keep the controller from trusting it.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            instr_done_out  <= 1'h0;
            instr_multi_out <= 1'h0;
            ret_done_out    <= 1'h0;
        end else begin
            instr_done_out  <= go_in;
            instr_multi_out <= go_in ? multi_in : ~instr_multi_out;
            ret_done_out    <= go_in & ret_in;
        end
    end

    // The long call follows an offer after a chosen delay, for one cycle.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in || !vec_valid_in || vec_ack_out) begin
            wait_q      <= 2'h0;
            vec_ack_out <= 1'h0;
        end else if (wait_q == ack_delay_in) begin
            vec_ack_out <= 1'h1;
        end else begin
            wait_q <= wait_q + 2'h1;
        end
    end
endmodule : icp_cpu_model

// ---- icp_ctrl_bench.sv ----
module icp_ctrl_bench
    import icp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [3:0] src;
        logic       glob;
        logic       en;
        logic       offer;
    } icp_row_type;

    logic                ref_clk_in;
    logic                resetn_in    = 1'h0;
    logic                hsel_in      = 1'h0;
    logic [DATA_W-1:0]   haddr_in     = 32'h0;
    logic [1:0]          htrans_in    = 2'h0;
    logic                hwrite_in    = 1'h0;
    logic [DATA_W-1:0]   hwdata_in    = 32'h0;
    logic [NUM_SRC-1:0]  src_event_in = 14'h0;
    logic [PIN_NUM-1:0]  ext_pin_in   = 2'h3;
    logic                go           = 1'h0;
    logic                go_multi     = 1'h0;
    logic                go_ret       = 1'h0;
    logic [1:0]          ack_delay    = 2'h0;
    logic                hreadyout_out, hresp_out, irq_req_out;
    logic                vec_valid_out, irq_out, vec_ack_in;
    logic                instr_done_in, instr_multi_in, ret_done_in;
    logic [DATA_W-1:0]   hrdata_out, rd;
    logic [VEC_W-1:0]    vec_addr_out;
    logic [IDX_W-1:0]    vec_src_out;
    int                  n_mismatch   = 0;
    int                  check_count  = 0;
    icp_row_type         rows [17]    = '{
        '{4'h0, 1'h1, 1'h1, 1'h1}, '{4'h1, 1'h1, 1'h1, 1'h1},
        '{4'h2, 1'h1, 1'h1, 1'h1}, '{4'h3, 1'h1, 1'h1, 1'h1},
        '{4'h4, 1'h1, 1'h1, 1'h1}, '{4'h5, 1'h1, 1'h1, 1'h1},
        '{4'h6, 1'h1, 1'h1, 1'h1}, '{4'h7, 1'h1, 1'h1, 1'h1},
        '{4'h8, 1'h1, 1'h1, 1'h1}, '{4'h9, 1'h1, 1'h1, 1'h1},
        '{4'hA, 1'h1, 1'h1, 1'h1}, '{4'hB, 1'h1, 1'h1, 1'h1},
        '{4'hC, 1'h1, 1'h1, 1'h1}, '{4'hD, 1'h1, 1'h1, 1'h1},
        '{4'h4, 1'h0, 1'h1, 1'h0}, '{4'hA, 1'h1, 1'h0, 1'h0},
        '{4'h6, 1'h0, 1'h0, 1'h0}};

    icp_ctrl icp_ctrl_i (.ref_clk_in, .resetn_in, .hsel_in, .haddr_in,
        .htrans_in, .hwrite_in, .hsize_in(3'h2), .hwdata_in,
        .hready_in(hreadyout_out), .hreadyout_out, .hresp_out, .hrdata_out,
        .src_event_in, .ext_pin_in, .instr_done_in, .instr_multi_in,
        .ret_done_in, .vec_ack_in, .irq_req_out, .vec_valid_out,
        .vec_addr_out, .vec_src_out, .irq_out);

    icp_cpu_model icp_cpu_model_i (.ref_clk_in, .resetn_in, .go_in(go),
        .multi_in(go_multi), .ret_in(go_ret), .ack_delay_in(ack_delay),
        .vec_valid_in(vec_valid_out), .instr_done_out(instr_done_in),
        .instr_multi_out(instr_multi_in), .ret_done_out(ret_done_in),
        .vec_ack_out(vec_ack_in));

    initial begin
        ref_clk_in = 1'h0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge ref_clk_in);
        while (hreadyout_out !== 1'h1) begin
            n++;
            if (n > 50) begin
                n_mismatch++;
                give_verdict();
            end
            @(posedge ref_clk_in);
        end
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [OFF_W-1:0] a,
                       input logic [31:0] wd);
        hsel_in   <= 1'h1;
        htrans_in <= 2'h2;
        haddr_in  <= {24'h0, a};
        hwrite_in <= wr;
        wait_ready();
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        wait_ready();
        rd = hrdata_out;
    endtask : bus

    task automatic check_reg(input logic [OFF_W-1:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        cmp_word(rd, e);
    endtask : check_reg

    task automatic check_level(input logic sel, input logic e);
        @(negedge ref_clk_in);
        cmp_bit(sel ? irq_out : irq_req_out, e);
        @(posedge ref_clk_in);
    endtask : check_level

    task automatic step(input logic m, input logic r);
        go       <= 1'h1;
        go_multi <= m;
        go_ret   <= r;
        @(posedge ref_clk_in);
        go <= 1'h0;
        @(posedge ref_clk_in);
    endtask : step

    task automatic fire(input logic [NUM_SRC-1:0] m);
        src_event_in <= m;
        @(posedge ref_clk_in);
        src_event_in <= SRC_ZERO;
        @(posedge ref_clk_in);
    endtask : fire

    task automatic finish_svc(input logic [NUM_SRC-1:0] m);
        bus(1'h1, OFF_PEND, {18'h0, m});
        step(1'h0, 1'h1);
        step(1'h0, 1'h0);
    endtask : finish_svc

    // Watches one offer through to its long call, or its absence.
    task automatic expect_offer(input logic exp, input logic [3:0] s);
        logic             seen;
        logic [VEC_W-1:0] va;
        seen = 1'h0;
        va = VEC_BASE + (VEC_W'(s) << VEC_SHIFT);
        for (int n = 0; n < 12; n++) begin
            @(negedge ref_clk_in);
            if (vec_valid_out === 1'h1 && !seen) begin
                seen = 1'h1;
                cmp_word({16'h0, vec_addr_out}, {16'h0, va});
                cmp_word({28'h0, vec_src_out}, {28'h0, s});
            end
            if (seen && vec_valid_out === 1'h0) break;
        end
        cmp_bit(seen, exp);
        @(posedge ref_clk_in);
    endtask : expect_offer

    initial begin
        #900us;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        logic [NUM_SRC-1:0] m;
        logic [NUM_SRC-1:0] one;
        resetn_in <= 1'h0;
        repeat (10) @(posedge ref_clk_in);
        resetn_in <= 1'h1;
        for (int i = 0; i < 17; i++) begin
            one = 14'h1 << rows[i].src;
            m = rows[i].en ? one : SRC_ZERO;
            ack_delay <= 2'(i);
            bus(1'h1, OFF_EN_MAIN, {24'h0, rows[i].glob, m[6:0]});
            bus(1'h1, OFF_EN_EXT1, {25'h0, m[13:7]});
            fire(one);
            check_reg(OFF_PEND, {18'h0, one});
            check_level(1'h0, rows[i].offer);
            step(1'h0, 1'h0);
            expect_offer(rows[i].offer, rows[i].src);
            if (rows[i].offer) finish_svc(one);
            else bus(1'h1, OFF_PEND, {18'h0, one});
        end
        for (int k = 1; k >= 0; k--) begin
            bus(1'h1, OFF_EN_MAIN, 32'h82);
            fire(14'h2);
            bus(1'h1, OFF_EN_MAIN, 32'h0);
            step(k[0], 1'h0);
            expect_offer(!k[0], 4'h1);
            check_reg(OFF_EN_MAIN, 32'h0);
            if (k == 0) finish_svc(14'h2);
            else bus(1'h1, OFF_PEND, 32'h2);
        end
        bus(1'h1, OFF_AUTOCLR, 32'h8);
        bus(1'h1, OFF_EN_MAIN, 32'h88);
        bus(1'h1, OFF_EN_EXT1, 32'h10);
        fire(14'h8);
        step(1'h0, 1'h0);
        expect_offer(1'h1, 4'h3);
        check_reg(OFF_PEND, 32'h0);
        finish_svc(SRC_ZERO);
        bus(1'h1, OFF_EVT_MSK, 32'h3);
        bus(1'h1, OFF_EVT, 32'h3);
        fire(14'h800);
        step(1'h0, 1'h0);
        expect_offer(1'h1, 4'hB);
        step(1'h0, 1'h1);
        expect_offer(1'h0, 4'hB);
        step(1'h0, 1'h0);
        expect_offer(1'h1, 4'hB);
        check_reg(OFF_EVT, 32'h3);
        check_level(1'h1, 1'h1);
        bus(1'h1, OFF_EVT_MSK, 32'h0);
        check_level(1'h1, 1'h0);
        bus(1'h1, OFF_EVT_MSK, 32'h3);
        bus(1'h1, OFF_EVT, 32'h3);
        check_level(1'h1, 1'h0);
        finish_svc(14'h800);
        bus(1'h1, OFF_PRIO, 32'h200);
        bus(1'h1, OFF_EN_MAIN, 32'hA8);
        bus(1'h1, OFF_EN_EXT1, 32'h4);
        fire(14'h28);
        step(1'h0, 1'h0);
        expect_offer(1'h1, 4'h3);
        fire(14'h200);
        step(1'h0, 1'h0);
        expect_offer(1'h1, 4'h9);
        step(1'h0, 1'h0);
        expect_offer(1'h0, 4'h5);
        finish_svc(14'h200);
        step(1'h0, 1'h0);
        expect_offer(1'h0, 4'h5);
        finish_svc(14'h8);
        expect_offer(1'h1, 4'h5);
        finish_svc(14'h20);
        ext_pin_in <= 2'h2;
        repeat (8) @(posedge ref_clk_in);
        ext_pin_in <= 2'h0;
        repeat (8) @(posedge ref_clk_in);
        check_reg(OFF_PEND, 32'h5);
        ext_pin_in <= 2'h3;
        fire(14'h3FFF);
        check_level(1'h0, 1'h1);
        resetn_in <= 1'h0;
        repeat (10) @(posedge ref_clk_in);
        resetn_in <= 1'h1;
        check_level(1'h0, 1'h0);
        cmp_bit(vec_valid_out, 1'h0);
        cmp_bit(hresp_out, 1'h0);
        bus(1'h1, 8'h20, 32'hFFFFFFFF);
        bus(1'h1, OFF_SVC, 32'hFFFFFFFF);
        for (int a = 0; a <= 32; a += 4) check_reg(8'(a), 32'h0);
        give_verdict();
    end
endmodule : icp_ctrl_bench
